// File: hw/uhl_pkg.sv
package uhl_pkg;

  // -------------------------------------------------------------------------
  // configuration space offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0]  CFG_BAR_OFS      = 8'h10;
  localparam logic [7:0]  CFG_LEG_OFS      = 8'h78;

  // -------------------------------------------------------------------------
  // capability window offsets
  // -------------------------------------------------------------------------
  localparam logic [7:0]  CAP_LEN_OFS      = 8'h00;
  localparam logic [7:0]  CAP_VER_OFS      = 8'h02;
  localparam logic [7:0]  CAP_STRUCT_OFS   = 8'h04;
  localparam logic [7:0]  CAP_PARAM_OFS    = 8'h08;

  // -------------------------------------------------------------------------
  // capability values
  // -------------------------------------------------------------------------
  localparam logic [7:0]  CAP_LEN_RESET    = 8'h20;
  localparam logic [15:0] CAP_VER_RESET    = 16'h0100;
  localparam int          CAP_VER_LSB      = 16;
  localparam logic [3:0]  DEBUG_PORT_INDEX = 4'h1;
  localparam logic [3:0]  NUM_COMPANIONS   = 4'h3;
  localparam logic [3:0]  PORTS_PER_COMP   = 4'h3;
  localparam logic [3:0]  NUM_PORTS        = 4'h8;
  localparam int          DEBUG_PORT_LSB   = 20;
  localparam int          NUM_COMP_LSB     = 12;
  localparam int          PORTS_COMP_LSB   = 8;
  localparam int          NUM_PORTS_LSB    = 0;
  localparam logic [31:0] CAP_STRUCT_RESET = 32'h00103308;
  localparam logic [31:0] CAP_PARAM_RESET  = 32'h00800070;
  localparam int          EXT_CAP_PTR_LSB  = 8;
  localparam int          ISO_THRESH_LSB   = 4;
  localparam int          PARK_CAP_BIT     = 2;
  localparam logic [1:0]  PARK_COUNT_DFLT  = 2'h3;

  // -------------------------------------------------------------------------
  // legacy enable/status layout
  // -------------------------------------------------------------------------
  localparam int          LEG_FLAG_LSB     = 16;
  localparam int          LEG_EN_LSB       = 0;
  localparam int          LEG_NUM_BITS     = 14;
  localparam int          LEG_PORT_IDX     = 6;
  localparam int          LEG_PM_IDX       = 5;
  localparam int          LEG_ASYNC_IDX    = 4;
  localparam int          LEG_PERIODIC_IDX = 3;
  localparam int          LEG_CONFIG_IDX   = 2;
  localparam int          LEG_HALT_IDX     = 1;
  localparam int          LEG_RESET_IDX    = 0;
  localparam logic [31:0] LEG_RESET        = 32'h00000000;

  // -------------------------------------------------------------------------
  // bar layout
  // -------------------------------------------------------------------------
  localparam logic [31:0] BAR_RESET        = 32'h00000000;

  // merge write data into a word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_word,
                                           input logic [31:0] new_word,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

endpackage : uhl_pkg

// File: hw/uhl_change_flag.sv
`timescale 1ns/100ps
`default_nettype none

module uhl_change_flag #(
  parameter int W         = 1,
  parameter bit RISE_ONLY = 1'b0
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] sample,
  input  wire logic         clear,
  output logic              flag
);

  initial begin
    if (W < 1 || (RISE_ONLY && W != 1)) begin
      $error("uhl_change_flag: rise detection needs a single bit");
    end
  end

  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;
  logic         armed_reg;
  logic         armed_next;
  logic         flag_reg;
  logic         flag_next;
  logic         hit;

  // -------------------------------------------------------------------------
  // change detection
  // -------------------------------------------------------------------------
  // armed keeps the first sample after reset from looking like a change
  always_comb begin
    prev_next  = sample;
    armed_next = 1'b1;
    if (RISE_ONLY) begin
      hit = armed_reg & sample[0] & ~prev_reg[0];
    end else begin
      hit = armed_reg & (sample != prev_reg);
    end
    // a new event in the clearing cycle keeps the flag set
    flag_next = hit | (flag_reg & ~clear);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_reg  <= '0;
      armed_reg <= 1'b0;
      flag_reg  <= 1'b0;
    end else begin
      prev_reg  <= prev_next;
      armed_reg <= armed_next;
      flag_reg  <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule : uhl_change_flag

`default_nettype wire

// File: hw/uhl_bar_decode.sv
`timescale 1ns/100ps
`default_nettype none

module uhl_bar_decode #(
  parameter int SIZE_BITS = 8
) (
  input  wire logic [31:0]          addr,
  input  wire logic [31:0]          base,
  input  wire logic                 enable,
  output logic                      hit,
  output logic [SIZE_BITS-1:0]      offset
);

  initial begin
    if (SIZE_BITS < 4 || SIZE_BITS > 31) begin
      $error("uhl_bar_decode: window size out of range");
    end
  end

  // an unprogrammed base never decodes, so reset cannot claim page zero
  assign hit    = enable && (base[31:SIZE_BITS] != '0) && (addr[31:SIZE_BITS] == base[31:SIZE_BITS]);
  assign offset = addr[SIZE_BITS-1:0];

endmodule : uhl_bar_decode

`default_nettype wire

// File: hw/uhl_regs.sv
// What this block does
// - eight port owner-change flags, bits 29..22, set on owner change, write one clears.
// - bit 21 sets when power management state changes; write one clears.
// - bit 20 sets when async schedule enable changes; write one clears.
// - bit 19 sets when periodic schedule enable changes; write one clears.
// - bit 18 sets when configure flag changes; write one clears.
// - bit 17 sets only on halted rising edge; write one clears.
// - bit 16 sets only on host reset rising edge; write one clears.
// - matching read/write enables: port enables 13..6, single enables 5..0.
// - reserved legacy bits read zero, ignore writes; register resets to zero.
// - capability window decoded at memory base from config bar at 10h.
// - capability length at offset zero reads 20h.
// - interface version at offset 02h reads 0100h.
// - structural parameters read 00103308h; debug port field names first port.
// - companion count, ports per companion and port count read only.
// - capability parameters reset 00800070h; extended capability pointer read only.
// - isochronous threshold bits 7..4 writable only by system writes.
// - park capability in bit 2 of capability parameters.
// - with park capability, park mode enable defaults 1 and count 3.
`timescale 1ns/100ps
`default_nettype none

module uhl_regs #(
  parameter int BAR_SIZE_BITS = 8,
  parameter int POWER_MGMT_CTRL_STATUS_W        = 2
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              cfg_rd,
  input  wire logic              cfg_wr,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [3:0]        cfg_be,
  input  wire logic [31:0]       cfg_wdata,
  output logic      [31:0]       cfg_rdata,
  output logic                   cfg_ack,
  input  wire logic              mem_space_en,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic [31:0]       mem_addr,
  input  wire logic [3:0]        mem_be,
  input  wire logic [31:0]       mem_wdata,
  input  wire logic              sys_wr_en,
  output logic                   mem_hit,
  output logic      [31:0]       mem_rdata,
  output logic                   mem_ack,
  input  wire logic [7:0]        port_owner,
  input  wire logic [POWER_MGMT_CTRL_STATUS_W-1:0] power_mgmt_ctrl_status,
  input  wire logic              async_sched_enable,
  input  wire logic              periodic_sched_enable,
  input  wire logic              config_flag,
  input  wire logic              hc_halted,
  input  wire logic              hc_reset,
  output logic                   legacy_smi_request,
  output logic                   park_capability,
  output logic                   park_mode_default,
  output logic      [1:0]        park_count_default,
  output logic      [3:0]        iso_threshold
);

  initial begin
    if (BAR_SIZE_BITS < 8 || BAR_SIZE_BITS > 31 || POWER_MGMT_CTRL_STATUS_W < 1) begin
      $error("uhl_regs: unsupported parameter values");
    end
  end

  localparam int NB = uhl_pkg::LEG_NUM_BITS;

  // -------------------------------------------------------------------------
  // change flags
  // -------------------------------------------------------------------------
  logic [NB-1:0] flags;
  logic [NB-1:0] flag_clear;
  logic [NB-1:0] enables_reg;
  logic [NB-1:0] enables_next;
  logic          leg_wr;
  logic [31:0]   leg_word;

  assign leg_wr = cfg_wr && (cfg_addr[7:2] == uhl_pkg::CFG_LEG_OFS[7:2]);

  // write one clears, only in byte lanes that were enabled
  always_comb begin
    flag_clear = '0;
    if (leg_wr) begin
      flag_clear = NB'(uhl_pkg::be_merge(32'h00000000, cfg_wdata, cfg_be) >> uhl_pkg::LEG_FLAG_LSB);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_port
      uhl_change_flag #(.W(1), .RISE_ONLY(1'b0)) u_port (
        .clock   (clock),
        .reset_n (reset_n),
        .sample  (port_owner[gi]),
        .clear   (flag_clear[uhl_pkg::LEG_PORT_IDX + gi]),
        .flag    (flags[uhl_pkg::LEG_PORT_IDX + gi])
      );
    end
  endgenerate

  uhl_change_flag #(.W(POWER_MGMT_CTRL_STATUS_W), .RISE_ONLY(1'b0)) u_pm (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (power_mgmt_ctrl_status),
    .clear   (flag_clear[uhl_pkg::LEG_PM_IDX]),
    .flag    (flags[uhl_pkg::LEG_PM_IDX])
  );

  uhl_change_flag #(.W(1), .RISE_ONLY(1'b0)) u_async (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (async_sched_enable),
    .clear   (flag_clear[uhl_pkg::LEG_ASYNC_IDX]),
    .flag    (flags[uhl_pkg::LEG_ASYNC_IDX])
  );

  uhl_change_flag #(.W(1), .RISE_ONLY(1'b0)) u_periodic (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (periodic_sched_enable),
    .clear   (flag_clear[uhl_pkg::LEG_PERIODIC_IDX]),
    .flag    (flags[uhl_pkg::LEG_PERIODIC_IDX])
  );

  uhl_change_flag #(.W(1), .RISE_ONLY(1'b0)) u_config (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (config_flag),
    .clear   (flag_clear[uhl_pkg::LEG_CONFIG_IDX]),
    .flag    (flags[uhl_pkg::LEG_CONFIG_IDX])
  );

  // a falling halted edge is not an event
  uhl_change_flag #(.W(1), .RISE_ONLY(1'b1)) u_halt (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (hc_halted),
    .clear   (flag_clear[uhl_pkg::LEG_HALT_IDX]),
    .flag    (flags[uhl_pkg::LEG_HALT_IDX])
  );

  uhl_change_flag #(.W(1), .RISE_ONLY(1'b1)) u_reset (
    .clock   (clock),
    .reset_n (reset_n),
    .sample  (hc_reset),
    .clear   (flag_clear[uhl_pkg::LEG_RESET_IDX]),
    .flag    (flags[uhl_pkg::LEG_RESET_IDX])
  );

  // -------------------------------------------------------------------------
  // enables and request
  // -------------------------------------------------------------------------
  logic smi_reg;
  logic smi_next;

  always_comb begin
    enables_next = enables_reg;
    if (leg_wr) begin
      enables_next = NB'(uhl_pkg::be_merge({18'h00000, enables_reg}, cfg_wdata, cfg_be));
    end
    smi_next = |(flags & enables_reg);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      enables_reg <= NB'(uhl_pkg::LEG_RESET);
      smi_reg     <= 1'b0;
    end else begin
      enables_reg <= enables_next;
      smi_reg     <= smi_next;
    end
  end

  assign legacy_smi_request = smi_reg;

  // reserved bits are constant zero; writes to them land nowhere
  assign leg_word = {2'b00, flags, 2'b00, enables_reg};

  // -------------------------------------------------------------------------
  // base address and config reads
  // -------------------------------------------------------------------------
  logic [31:0] bar_reg;
  logic [31:0] bar_next;
  logic [31:0] cfg_rdata_reg;
  logic [31:0] cfg_rdata_next;
  logic        cfg_ack_reg;
  logic        cfg_ack_next;
  logic [31:0] bar_mask;

  // low bits are hardwired zero: 32-bit non-prefetchable memory window
  assign bar_mask = ~((32'h00000001 << BAR_SIZE_BITS) - 32'h00000001);

  always_comb begin
    bar_next       = bar_reg;
    cfg_rdata_next = cfg_rdata_reg;
    cfg_ack_next   = cfg_rd | cfg_wr;
    if (cfg_wr && (cfg_addr[7:2] == uhl_pkg::CFG_BAR_OFS[7:2])) begin
      bar_next = uhl_pkg::be_merge(bar_reg, cfg_wdata, cfg_be) & bar_mask;
    end
    if (cfg_rd) begin
      if (cfg_addr[7:2] == uhl_pkg::CFG_BAR_OFS[7:2]) begin
        cfg_rdata_next = bar_reg;
      end else if (cfg_addr[7:2] == uhl_pkg::CFG_LEG_OFS[7:2]) begin
        cfg_rdata_next = leg_word;
      end else begin
        cfg_rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bar_reg       <= uhl_pkg::BAR_RESET;
      cfg_rdata_reg <= 32'h00000000;
      cfg_ack_reg   <= 1'b0;
    end else begin
      bar_reg       <= bar_next;
      cfg_rdata_reg <= cfg_rdata_next;
      cfg_ack_reg   <= cfg_ack_next;
    end
  end

  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_ack   = cfg_ack_reg;

  // -------------------------------------------------------------------------
  // capability window
  // -------------------------------------------------------------------------
  logic [BAR_SIZE_BITS-1:0] mem_ofs;
  logic [3:0]               ist_reg;
  logic [3:0]               ist_next;
  logic                     park_reg;
  logic                     park_next;
  logic [31:0]              mem_rdata_reg;
  logic [31:0]              mem_rdata_next;
  logic                     mem_ack_reg;
  logic                     mem_ack_next;
  logic [31:0]              param_word;
  logic [31:0]              struct_word;
  logic [5:0]               mem_dw;
  logic [31:0]              merged;

  uhl_bar_decode #(.SIZE_BITS(BAR_SIZE_BITS)) u_decode (
    .addr    (mem_addr),
    .base    (bar_reg),
    .enable  (mem_space_en),
    .hit     (mem_hit),
    .offset  (mem_ofs)
  );

  assign mem_dw = mem_ofs[7:2];

  assign struct_word = (32'(uhl_pkg::DEBUG_PORT_INDEX) << uhl_pkg::DEBUG_PORT_LSB)
                     | (32'(uhl_pkg::NUM_COMPANIONS)   << uhl_pkg::NUM_COMP_LSB)
                     | (32'(uhl_pkg::PORTS_PER_COMP)   << uhl_pkg::PORTS_COMP_LSB)
                     | (32'(uhl_pkg::NUM_PORTS)        << uhl_pkg::NUM_PORTS_LSB);

  // upper half and pointer stay at their reset value; only threshold and park move
  always_comb begin
    param_word = uhl_pkg::CAP_PARAM_RESET;
    param_word[uhl_pkg::ISO_THRESH_LSB +: 4] = ist_reg;
    param_word[uhl_pkg::PARK_CAP_BIT]        = park_reg;
  end

  always_comb begin
    ist_next       = ist_reg;
    park_next      = park_reg;
    mem_rdata_next = mem_rdata_reg;
    mem_ack_next   = mem_hit & (mem_rd | mem_wr);
    merged         = uhl_pkg::be_merge(param_word, mem_wdata, mem_be);
    if (mem_hit && mem_wr && sys_wr_en && (mem_dw == uhl_pkg::CAP_PARAM_OFS[7:2])) begin
      ist_next  = merged[uhl_pkg::ISO_THRESH_LSB +: 4];
      park_next = merged[uhl_pkg::PARK_CAP_BIT];
    end
    if (mem_hit && mem_rd) begin
      unique case (mem_dw)
        uhl_pkg::CAP_LEN_OFS[7:2]:    mem_rdata_next = (32'(uhl_pkg::CAP_VER_RESET) << uhl_pkg::CAP_VER_LSB)
                                                     | 32'(uhl_pkg::CAP_LEN_RESET);
        uhl_pkg::CAP_STRUCT_OFS[7:2]: mem_rdata_next = struct_word;
        uhl_pkg::CAP_PARAM_OFS[7:2]:  mem_rdata_next = param_word;
        default:                      mem_rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ist_reg       <= uhl_pkg::CAP_PARAM_RESET[uhl_pkg::ISO_THRESH_LSB +: 4];
      park_reg      <= uhl_pkg::CAP_PARAM_RESET[uhl_pkg::PARK_CAP_BIT];
      mem_rdata_reg <= 32'h00000000;
      mem_ack_reg   <= 1'b0;
    end else begin
      ist_reg       <= ist_next;
      park_reg      <= park_next;
      mem_rdata_reg <= mem_rdata_next;
      mem_ack_reg   <= mem_ack_next;
    end
  end

  assign mem_rdata          = mem_rdata_reg;
  assign mem_ack            = mem_ack_reg;
  assign iso_threshold      = ist_reg;
  assign park_capability    = park_reg;
  // defaults the command register loads from when parking is supported
  assign park_mode_default  = park_reg;
  assign park_count_default = park_reg ? uhl_pkg::PARK_COUNT_DFLT : 2'h0;

endmodule : uhl_regs

`default_nettype wire

// File: test/uhl_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module uhl_regs_assertions (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        cfg_rd,
  input wire logic        cfg_wr,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_ack,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic        sys_wr_en,
  input wire logic        mem_hit,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_ack,
  input wire logic        legacy_smi_request,
  input wire logic        park_capability,
  input wire logic        park_mode_default,
  input wire logic [1:0]  park_count_default,
  input wire logic [3:0]  iso_threshold
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // ---------------------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------------------
  cfg_ack_resp_a: assert property ((cfg_rd || cfg_wr) |=> cfg_ack)
    else $error("config request not answered");
  cfg_ack_idle_a: assert property (!(cfg_rd || cfg_wr) |=> !cfg_ack)
    else $error("config ack without request");
  mem_ack_hit_a: assert property ((mem_hit && (mem_rd || mem_wr)) |=> mem_ack)
    else $error("window access not answered");
  mem_ack_miss_a: assert property (!(mem_hit && (mem_rd || mem_wr)) |=> !mem_ack)
    else $error("window ack without hit");

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  leg_reserved_zero_a: assert property ((cfg_ack && $past(cfg_rd && cfg_addr == 8'h78))
    |-> (cfg_rdata[31:30] == 2'h0 && cfg_rdata[15:14] == 2'h0)) else $error("reserved legacy bits set");
  smi_follows_flags_a: assert property ((cfg_ack && $past(cfg_rd && cfg_addr == 8'h78))
    |-> legacy_smi_request == |(cfg_rdata[29:16] & cfg_rdata[13:0])) else $error("smi request mismatch");
  cap_head_read_a: assert property ((mem_ack && $past(mem_rd && mem_addr[7:0] == 8'h00))
    |-> mem_rdata == 32'h01000020) else $error("length or version wrong");
  struct_read_a: assert property ((mem_ack && $past(mem_rd && mem_addr[7:0] == 8'h04))
    |-> mem_rdata == 32'h00103308) else $error("structural parameters wrong");
  param_fixed_a: assert property ((mem_ack && $past(mem_rd && mem_addr[7:0] == 8'h08))
    |-> (mem_rdata[31:8] == 24'h008000 && mem_rdata[3] == 1'b0 && mem_rdata[1:0] == 2'h0
         && mem_rdata[2] == park_capability && mem_rdata[7:4] == iso_threshold))
    else $error("capability parameters wrong");

  // ---------------------------------------------------------------------------
  // system-write fields
  // ---------------------------------------------------------------------------
  // the past-reset term keeps a one-cycle reset from looking like a write
  iso_guard_a: assert property (($changed(iso_threshold) && $past(reset_n))
    |-> $past(mem_wr && mem_hit && sys_wr_en)) else $error("threshold changed without system write");
  park_defaults_a: assert property (park_mode_default == park_capability
    && park_count_default == (park_capability ? 2'h3 : 2'h0)) else $error("park defaults wrong");

  smi_rise_c: cover property ($rose(legacy_smi_request));
  cfg_write_c: cover property (cfg_wr ##1 cfg_ack);
  mem_read_c: cover property (mem_rd && mem_hit ##1 mem_ack);
  park_on_c: cover property ($rose(park_capability));
endmodule : uhl_regs_assertions

bind uhl_regs uhl_regs_assertions chk (
  .clock(clock), .reset_n(reset_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
  .sys_wr_en(sys_wr_en), .mem_hit(mem_hit), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .legacy_smi_request(legacy_smi_request), .park_capability(park_capability),
  .park_mode_default(park_mode_default), .park_count_default(park_count_default),
  .iso_threshold(iso_threshold)
);

`default_nettype wire

// File: test/uhl_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none

module uhl_regs_bench;
  localparam logic [31:0] BAR = 32'h12345600;
  logic        clock, reset_n, cfg_rd, cfg_wr, cfg_ack, mem_space_en, mem_rd, mem_wr, sys_wr_en, mem_hit;
  logic        mem_ack, async_sched_enable, periodic_sched_enable, config_flag, hc_halted, hc_reset;
  logic        legacy_smi_request, park_capability, park_mode_default;
  logic [1:0]  power_mgmt_ctrl_status, park_count_default;
  logic [3:0]  cfg_be, mem_be, iso_threshold;
  logic [7:0]  cfg_addr, port_owner;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr, mem_wdata, mem_rdata, q, b;
  int          fails, num_checks;

  uhl_regs #(.BAR_SIZE_BITS(8), .POWER_MGMT_CTRL_STATUS_W(2)) uut (
    .clock(clock), .reset_n(reset_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .mem_space_en(mem_space_en), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_be(mem_be),
    .mem_wdata(mem_wdata), .sys_wr_en(sys_wr_en), .mem_hit(mem_hit), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .port_owner(port_owner), .power_mgmt_ctrl_status(power_mgmt_ctrl_status),
    .async_sched_enable(async_sched_enable), .periodic_sched_enable(periodic_sched_enable),
    .config_flag(config_flag), .hc_halted(hc_halted), .hc_reset(hc_reset),
    .legacy_smi_request(legacy_smi_request), .park_capability(park_capability),
    .park_mode_default(park_mode_default), .park_count_default(park_count_default),
    .iso_threshold(iso_threshold)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end

  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // requests are single-cycle pulses; the answer is awaited under a bound
  task bus(input bit m, input bit w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d,
           input bit want);
    int n;
    @(posedge clock);
    #1;
    if (m) {mem_rd, mem_wr, mem_addr, mem_be, mem_wdata} = {!w, w, a, be, d};
    else {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {!w, w, a[7:0], be, d};
    @(posedge clock);
    #1;
    {mem_rd, mem_wr, cfg_rd, cfg_wr} = 4'h0;
    n = 0;
    while ((m ? mem_ack : cfg_ack) !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    q = m ? mem_rdata : cfg_rdata;
    check(n < 4, want);
    if (want && n >= 4) end_sim;
  endtask : bus

  task cw(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    bus(1'b0, 1'b1, a, be, d, 1'b1);
  endtask : cw
  task cr(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, 1'b0, a, 4'hF, 32'h0, 1'b1);
    check(q, exp);
  endtask : cr
  task mw(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
    bus(1'b1, 1'b1, a, be, d, 1'b1);
  endtask : mw
  task mr(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b1, 1'b0, a, 4'hF, 32'h0, 1'b1);
    check(q, exp);
  endtask : mr

  // event k pairs with flag 16+k and enable k
  task poke(input int k);
    @(posedge clock);
    #1;
    if (k >= 6) port_owner[k-6] = !port_owner[k-6];
    else if (k == 0) hc_reset = !hc_reset;
    else if (k == 1) hc_halted = !hc_halted;
    else if (k == 2) config_flag = !config_flag;
    else if (k == 3) periodic_sched_enable = !periodic_sched_enable;
    else if (k == 4) async_sched_enable = !async_sched_enable;
    else power_mgmt_ctrl_status[0] = !power_mgmt_ctrl_status[0];
    @(posedge clock);
    #1;
  endtask : poke

  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    {reset_n, cfg_rd, cfg_wr, mem_space_en, mem_rd, mem_wr, sys_wr_en} = 7'h0;
    {async_sched_enable, periodic_sched_enable, config_flag, hc_halted, hc_reset} = 5'h0;
    {cfg_be, mem_be, cfg_addr, port_owner, power_mgmt_ctrl_status} = 26'h0;
    {cfg_wdata, mem_addr, mem_wdata} = 96'h0;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge clock);
    #1;
    reset_n = 1'b1;
    cr(8'h78, 32'h0);
    cr(8'h10, 32'h0);
    check(iso_threshold, 4'h7);
    check({park_capability, park_mode_default, park_count_default}, 4'h0);
    check(legacy_smi_request, 1'b0);
    $display("test reset values done");

    cw(8'h10, 4'hF, BAR);
    cr(8'h10, BAR);
    mem_space_en = 1'b1;
    mr(BAR, 32'h01000020);
    mr(BAR + 32'h4, 32'h00103308);
    mr(BAR + 32'h8, 32'h00800070);
    mr(BAR + 32'h20, 32'h0);
    check(mem_hit, 1'b1);
    bus(1'b1, 1'b0, 32'h00000004, 4'hF, 32'h0, 1'b0);
    check(mem_hit, 1'b0);
    mem_space_en = 1'b0;
    bus(1'b1, 1'b0, BAR, 4'hF, 32'h0, 1'b0);
    mem_space_en = 1'b1;
    $display("test window decode done");

    mw(BAR, 4'hF, 32'hFFFFFFFF);
    mw(BAR + 32'h4, 4'hF, 32'hFFFFFFFF);
    mw(BAR + 32'h8, 4'hF, 32'hFFFFFFFF);
    mr(BAR, 32'h01000020);
    mr(BAR + 32'h4, 32'h00103308);
    mr(BAR + 32'h8, 32'h00800070);
    sys_wr_en = 1'b1;
    mw(BAR + 32'h8, 4'hF, 32'hFFFFFFFF);
    mr(BAR + 32'h8, 32'h008000F4);
    check({iso_threshold, park_capability, park_mode_default, park_count_default}, 8'hFF);
    mw(BAR + 32'h8, 4'hF, 32'h00000004);
    mr(BAR + 32'h8, 32'h00800004);
    mw(BAR + 32'h8, 4'hF, 32'h00000030);
    mr(BAR + 32'h8, 32'h00800030);
    check({park_mode_default, park_count_default}, 3'h0);
    sys_wr_en = 1'b0;
    $display("test capability fields done");

    cw(8'h78, 4'hF, 32'hFFFFFFFF);
    cr(8'h78, 32'h00003FFF);
    cw(8'h78, 4'hF, 32'h0);
    cr(8'h78, 32'h0);
    $display("test legacy enables done");

    for (int k = 0; k < 14; k++) begin
      b = 32'h1 << (16 + k);
      poke(k);
      cr(8'h78, b);
      check(legacy_smi_request, 1'b0);
      cw(8'h78, 4'hF, 32'h0);
      cr(8'h78, b);
      cw(8'h78, 4'hF, b);
      cr(8'h78, 32'h0);
      poke(k);
      cr(8'h78, (k < 2) ? 32'h0 : b);
      cw(8'h78, 4'hF, b);
    end
    $display("test change flags done");

    cw(8'h78, 4'hF, 32'h00000002);
    poke(1);
    repeat (2) @(posedge clock);
    #1;
    check(legacy_smi_request, 1'b1);
    cr(8'h78, 32'h00020002);
    cw(8'h78, 4'h3, 32'hFFFF0002);
    cr(8'h78, 32'h00020002);
    cw(8'h78, 4'hC, 32'h00020000);
    repeat (2) @(posedge clock);
    #1;
    check(legacy_smi_request, 1'b0);
    cr(8'h78, 32'h00000002);
    $display("test smi request done");

    // mid-run reset: halted input stays high, so only a false edge could set a flag
    @(posedge clock);
    #1;
    reset_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    cr(8'h78, 32'h0);
    check(mem_hit, 1'b0);
    check(iso_threshold, 4'h7);
    check(legacy_smi_request, 1'b0);
    $display("test mid-run reset done");
    end_sim;
  end
endmodule : uhl_regs_bench

`default_nettype wire
